// *** logic/pioc_top.sv ***
// Parallel I/O controller: APB registers, output drive, open drain, filtered pin sampling
//
// Functional notes
// R1 - Set and clear registers change outputs separately
// R2 - Output data write updates lines at once
// R3 - Output data write only where mask set
// R4 - Mask set and mask clear registers
// R5 - Mask status resets to zero
// R6 - Open drain lines only drive low
// R7 - Open drain enable, disable, status registers
// R8 - Open drain also applies to peripheral drive
// R9 - Open drain status resets to zero
// R10 - Pin level register shows actual line levels
// R11 - Clock stopped keeps last sampled levels
// R12 - Per-line glitch filter enable and disable
// R13 - Filter rejects pulses under half master cycle; code rejects only one-cycle spikes, longer pulses pass at the next master edge
// R14 - Filter passes pulses of one master cycle
// R15 - Zero bits in set/clear have no effect
`timescale 1ns/1ps
module pioc_top #(
	parameter int unsigned LINES = 32
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic master_clock_in,
	input wire logic ctrl_clk_en_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [LINES-1:0] pad_in,
	input wire logic [LINES-1:0] periph_out_in,
	input wire logic [LINES-1:0] periph_oe_in,
	output logic [LINES-1:0] pad_out,
	output logic [LINES-1:0] pad_oe_out
);

	// ------------------------------------------------------------
	// Register map (byte offsets, one word each)
	// ------------------------------------------------------------
	// 0x00 set_output_reg: ones raise output bits
	// 0x04 clear_output_reg: ones lower output bits
	// 0x08 output_data_reg: masked direct write, readable
	// 0x0C output_write_mask_set
	// 0x10 output_write_mask_clear
	// 0x14 output_write_mask_status
	// 0x18 open_drain_enable_reg
	// 0x1C open_drain_disable_reg
	// 0x20 open_drain_status_reg
	// 0x24 pin_level_reg
	// 0x28 filter enable
	// 0x2C filter disable
	// 0x30 filter status
	// 0x34 output enable
	// 0x38 output disable
	// 0x3C output enable status
	// 0x40 peripheral select, one means peripheral drives
	// Other offsets read zero and ignore writes

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	// Bus words are 32 bits, so no more lines fit one register
	if (LINES < 1 || LINES > 32) begin
		$error("pioc_top: LINES must be 1 to 32");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [LINES-1:0] out_data;
		logic [LINES-1:0] out_en;
		logic [LINES-1:0] wr_mask;
		logic [LINES-1:0] od_en;
		logic [LINES-1:0] filt_en;
		logic [LINES-1:0] periph_sel;
		logic [LINES-1:0] sync1;
		logic [LINES-1:0] sync2;
		logic [LINES-1:0] sync3;
		logic [LINES-1:0] filt_lvl;
		logic [LINES-1:0] filt_chg;
		logic [LINES-1:0] filt_val;
		logic [LINES-1:0] pin_lvl;
		logic mck1;
		logic mck2;
		logic mck3;
		logic [31:0] prdata;
		logic pready;
		logic slverr;
		logic [LINES-1:0] pad_o;
		logic [LINES-1:0] pad_oe;
	} pioc_state_t;

	pioc_state_t st_ff;
	pioc_state_t nxt_st;
	pioc_pkg::pioc_apb_req_t req;
	pioc_pkg::pioc_pad_t drive;

	assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
		paddr: paddr_in, pwdata: pwdata_in};

	function automatic logic [31:0] pioc_widen(input logic [LINES-1:0] v);
		logic [31:0] w;
		w = pioc_pkg::RST_ZERO;
		w[LINES-1:0] = v;
		return w;
	endfunction

	function automatic logic pioc_hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	// Read decode; write-only and unmapped offsets read zero
	function automatic logic [31:0] pioc_read(input logic [11:0] a, input pioc_state_t s);
		logic [31:0] w;
		unique case (a)
			pioc_pkg::ADDR_OUTPUT_DATA: w = pioc_widen(s.out_data);
			pioc_pkg::ADDR_MASK_STATUS: w = pioc_widen(s.wr_mask); // R4
			pioc_pkg::ADDR_OD_STATUS: w = pioc_widen(s.od_en); // R7
			pioc_pkg::ADDR_PIN_LEVEL: w = pioc_widen(s.pin_lvl); // R10
			pioc_pkg::ADDR_FILT_STATUS: w = pioc_widen(s.filt_en); // R12
			pioc_pkg::ADDR_OUT_STATUS: w = pioc_widen(s.out_en);
			pioc_pkg::ADDR_PERIPH_SEL: w = pioc_widen(s.periph_sel);
			default: w = pioc_pkg::READ_UNMAPPED;
		endcase
		return w;
	endfunction

	logic [LINES-1:0] wv;
	logic wr_acc;
	logic rd_setup;
	logic mck_tick;
	logic [LINES-1:0] drv_val;
	logic [LINES-1:0] drv_oe;
	logic [LINES-1:0] od_o;
	logic [LINES-1:0] od_oe;
	logic [LINES-1:0] filt_agree;
	logic [LINES-1:0] filt_seen;
	logic [LINES-1:0] nxt_filt_lvl;
	logic [LINES-1:0] nxt_filt_chg;
	logic [LINES-1:0] nxt_filt_val;
	logic [LINES-1:0] nxt_pin_lvl;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Two cycles per transfer: setup, then one access cycle with ready.
	// Read data is taken at setup and stands until the next setup,
	// so a read shows the registers as they were before that transfer.
	assign wv = req.pwdata[LINES-1:0];
	// A write lands only in the access cycle that shows ready
	assign wr_acc = req.psel && req.penable && req.pwrite && st_ff.pready;
	assign rd_setup = req.psel && !req.penable;
	// Master clock rising edge, seen after its synchroniser
	assign mck_tick = st_ff.mck2 && !st_ff.mck3;

	// ------------------------------------------------------------
	// Glitch filter, one per line
	// ------------------------------------------------------------
	// A level counts once two synchroniser stages agree on it; a filtered
	// line keeps it pending and takes it at the next master clock edge.
	// A one-cycle spike never agrees, so it never reaches the line, while
	// a pulse a whole master cycle long is always agreed and then applied.
	// Limitation: the master clock must run well below the system clock.
	for (genvar g = 0; g < LINES; g++) begin : g_filt
		assign filt_agree[g] = st_ff.sync2[g] == st_ff.sync3[g];
		assign filt_seen[g] = filt_agree[g] && (st_ff.sync3[g] != st_ff.filt_lvl[g]);
		assign nxt_filt_lvl[g] = !st_ff.filt_en[g] ?
			(filt_seen[g] ? st_ff.sync3[g] : st_ff.filt_lvl[g]) : // R12
			!mck_tick ? st_ff.filt_lvl[g] :
			filt_seen[g] ? st_ff.sync3[g] : // R13 R14
			st_ff.filt_chg[g] ? st_ff.filt_val[g] : st_ff.filt_lvl[g]; // R14
		assign nxt_filt_chg[g] = st_ff.filt_en[g] && !mck_tick &&
			(filt_seen[g] || st_ff.filt_chg[g]);
		assign nxt_filt_val[g] = filt_seen[g] ? st_ff.sync3[g] : st_ff.filt_val[g];
	end

	// ------------------------------------------------------------
	// Pin level sampling
	// ------------------------------------------------------------
	// With the controller clock gated off the last sampled levels
	// stay readable instead of following the pins.
	assign nxt_pin_lvl = ctrl_clk_en_in ? st_ff.filt_lvl : st_ff.pin_lvl; // R10 R11

	// ------------------------------------------------------------
	// Output drive, one per line
	// ------------------------------------------------------------
	// Source is chosen before open drain is applied, so open drain
	// covers peripheral-driven lines just as well.
	for (genvar g = 0; g < LINES; g++) begin : g_drv
		assign drv_val[g] = st_ff.periph_sel[g] ? periph_out_in[g] : st_ff.out_data[g];
		assign drv_oe[g] = st_ff.periph_sel[g] ? periph_oe_in[g] : st_ff.out_en[g];
		// Never drive high: release and let the pull-up make the level
		assign od_o[g] = st_ff.od_en[g] ? 1'b0 : drv_val[g]; // R6 R8
		assign od_oe[g] = st_ff.od_en[g] ? (drv_oe[g] && !drv_val[g]) : drv_oe[g]; // R6 R8
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// APB: ready in the first access cycle, never an error
		nxt_st.pready = rd_setup;
		nxt_st.slverr = 1'b0;

		if (wr_acc) begin
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_SET_OUTPUT)) begin
				nxt_st.out_data = st_ff.out_data | wv; // R1 R15
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_CLEAR_OUTPUT)) begin
				nxt_st.out_data = st_ff.out_data & ~wv; // R1 R15
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_OUTPUT_DATA)) begin
				// Lines whose mask bit is clear keep their value
				nxt_st.out_data = (st_ff.out_data & ~st_ff.wr_mask) | (wv & st_ff.wr_mask); // R2 R3
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_MASK_SET)) begin
				nxt_st.wr_mask = st_ff.wr_mask | wv; // R4
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_MASK_CLEAR)) begin
				nxt_st.wr_mask = st_ff.wr_mask & ~wv; // R4
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_OD_ENABLE)) begin
				nxt_st.od_en = st_ff.od_en | wv; // R7
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_OD_DISABLE)) begin
				nxt_st.od_en = st_ff.od_en & ~wv; // R7
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_FILT_ENABLE)) begin
				nxt_st.filt_en = st_ff.filt_en | wv; // R12
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_FILT_DISABLE)) begin
				nxt_st.filt_en = st_ff.filt_en & ~wv; // R12
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_OUT_ENABLE)) begin
				nxt_st.out_en = st_ff.out_en | wv;
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_OUT_DISABLE)) begin
				nxt_st.out_en = st_ff.out_en & ~wv;
			end
			if (pioc_hit(req.paddr, pioc_pkg::ADDR_PERIPH_SEL)) begin
				nxt_st.periph_sel = wv;
			end
		end

		// Read data captured at setup, held through access
		if (rd_setup) begin
			nxt_st.prdata = pioc_read(req.paddr, st_ff);
		end

		// Pin and master clock synchronisers
		nxt_st.sync1 = pad_in;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		nxt_st.mck1 = master_clock_in;
		nxt_st.mck2 = st_ff.mck1;
		nxt_st.mck3 = st_ff.mck2;

		// Filter and pin sampling, worked out per line above
		nxt_st.filt_lvl = nxt_filt_lvl;
		nxt_st.filt_chg = nxt_filt_chg;
		nxt_st.filt_val = nxt_filt_val;
		nxt_st.pin_lvl = nxt_pin_lvl;

		// Drive registered, so pins change one cycle after the write
		nxt_st.pad_o = od_o;
		nxt_st.pad_oe = od_oe;
	end

	assign drive = '{out: pioc_widen(st_ff.pad_o), oe: pioc_widen(st_ff.pad_oe)};

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			// Mask and open drain start off so no line moves unasked
			st_ff <= '0;
			st_ff.wr_mask <= pioc_pkg::RST_ZERO[LINES-1:0]; // R5
			st_ff.od_en <= pioc_pkg::RST_ZERO[LINES-1:0]; // R9
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata_out = st_ff.prdata;
	assign pready_out = st_ff.pready;
	assign pslverr_out = st_ff.slverr;
	assign pad_out = drive.out[LINES-1:0];
	assign pad_oe_out = drive.oe[LINES-1:0];

endmodule

// *** logic/pioc_pkg.sv ***
// Package: register map, field layout and reset values of the parallel I/O controller
package pioc_pkg;
	localparam int unsigned NUM_LINES = 32;
	localparam logic [11:0] ADDR_SET_OUTPUT = 12'h000;
	localparam logic [11:0] ADDR_CLEAR_OUTPUT = 12'h004;
	localparam logic [11:0] ADDR_OUTPUT_DATA = 12'h008;
	localparam logic [11:0] ADDR_MASK_SET = 12'h00C;
	localparam logic [11:0] ADDR_MASK_CLEAR = 12'h010;
	localparam logic [11:0] ADDR_MASK_STATUS = 12'h014;
	localparam logic [11:0] ADDR_OD_ENABLE = 12'h018;
	localparam logic [11:0] ADDR_OD_DISABLE = 12'h01C;
	localparam logic [11:0] ADDR_OD_STATUS = 12'h020;
	localparam logic [11:0] ADDR_PIN_LEVEL = 12'h024;
	localparam logic [11:0] ADDR_FILT_ENABLE = 12'h028;
	localparam logic [11:0] ADDR_FILT_DISABLE = 12'h02C;
	localparam logic [11:0] ADDR_FILT_STATUS = 12'h030;
	localparam logic [11:0] ADDR_OUT_ENABLE = 12'h034;
	localparam logic [11:0] ADDR_OUT_DISABLE = 12'h038;
	localparam logic [11:0] ADDR_OUT_STATUS = 12'h03C;
	localparam logic [11:0] ADDR_PERIPH_SEL = 12'h040;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// APB request as seen by the slave
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pioc_apb_req_t;

	// Per-line pin side signals
	typedef struct packed {
		logic [31:0] out;
		logic [31:0] oe;
	} pioc_pad_t;
endpackage

// *** verif/pioc_pad_model.sv ***
// Partner: pulled-up shared lines with external low drivers
`timescale 1ns/1ps
module pioc_pad_model #(
	parameter int unsigned LINES = 32
) (
	input wire logic [LINES-1:0] drv_in,
	input wire logic [LINES-1:0] oe_in,
	input wire logic [LINES-1:0] ext_low_in,
	output logic [LINES-1:0] level_out
);
	// Released lines float to the pull-up level; any low driver wins
	assign level_out = ~ext_low_in & (~oe_in | drv_in);
endmodule

// *** verif/pioc_chk.sv ***
// Checker: bus timing and open-drain drive of the I/O controller
`timescale 1ns/1ps
module pioc_chk #(
	parameter int unsigned LINES = 32
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [LINES-1:0] pad_out,
	input wire logic [LINES-1:0] pad_oe_out
);
	logic wr_ok;
	logic [LINES-1:0] od_ff;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_acc;
		psel_in && penable_in;
	endsequence
	assign wr_ok = psel_in && penable_in && pready_out && pwrite_in;
	// Shadow of the open-drain state, only to judge the drive
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in)
			od_ff <= '0;
		else if (wr_ok && paddr_in == pioc_pkg::ADDR_OD_ENABLE)
			od_ff <= od_ff | pwdata_in[LINES-1:0];
		else if (wr_ok && paddr_in == pioc_pkg::ADDR_OD_DISABLE)
			od_ff <= od_ff & ~pwdata_in[LINES-1:0];
	end
	a_ready_access: assert property (s_acc |-> pready_out)
		else $error("no ready in access");
	a_ready_cause: assert property (pready_out |-> s_acc)
		else $error("ready outside access");
	a_ready_pulse: assert property (s_acc ##0 pready_out |=> !pready_out)
		else $error("ready too long");
	a_err_zero: assert property (!pslverr_out)
		else $error("error response");
	a_rd_hold: assert property (pready_out ##1 !psel_in |-> $stable(prdata_out))
		else $error("read data moved");
	a_unmapped_zero: assert property (s_acc ##0 !pwrite_in && paddr_in > 12'h040
		|-> prdata_out == 32'h0) else $error("unmapped read not zero");
	a_od_low: assert property ((od_ff & $past(od_ff) & pad_oe_out & pad_out) == '0)
		else $error("open drain drove high");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_b_in |=> pad_oe_out == '0)
		else $error("drive after reset");
endmodule
bind pioc_top pioc_chk #(.LINES(LINES)) u_chk (.sys_clk_in, .rst_b_in, .psel_in, .penable_in,
	.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .pad_out,
	.pad_oe_out);

// *** verif/pioc_top_tb.sv ***
// Testbench: register and pad behaviour of the I/O controller
`timescale 1ns/1ps
module pioc_top_tb;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;} pioc_row_t;
	logic clk, rst_b, sel, en, wr, cke, pready, lowseen;
	logic [1:0] mcnt;
	logic [11:0] addr;
	logic [31:0] wd, rd, r, pdo, poe, ext, pad, po, pe;
	int err_total, samples_checked;
	pioc_row_t rows [19] = '{
		'{1'h0, 12'h014, 32'h0},
		'{1'h0, 12'h020, 32'h0},
		'{1'h1, 12'h034, 32'hFFFFFFFF},
		'{1'h1, 12'h000, 32'h000000FF},
		'{1'h1, 12'h004, 32'h0000000F},
		'{1'h0, 12'h008, 32'h000000F0},
		'{1'h1, 12'h008, 32'h12345678},
		'{1'h0, 12'h008, 32'h000000F0},
		'{1'h1, 12'h00C, 32'h0000FF00},
		'{1'h1, 12'h010, 32'h00000F00},
		'{1'h0, 12'h014, 32'h0000F000},
		'{1'h1, 12'h008, 32'hFFFFFFFF},
		'{1'h0, 12'h008, 32'h0000F0F0},
		'{1'h1, 12'h018, 32'h000000F0},
		'{1'h1, 12'h01C, 32'h00000030},
		'{1'h0, 12'h020, 32'h000000C0},
		'{1'h1, 12'h028, 32'h00000010},
		'{1'h0, 12'h030, 32'h00000010},
		'{1'h0, 12'h100, 32'h0}};
	pioc_top dut (.sys_clk_in(clk), .rst_b_in(rst_b), .master_clock_in(mcnt[1]),
		.ctrl_clk_en_in(cke), .psel_in(sel), .penable_in(en), .pwrite_in(wr),
		.paddr_in(addr), .pwdata_in(wd), .prdata_out(rd), .pready_out(pready),
		.pslverr_out(), .pad_in(pad), .periph_out_in(po), .periph_oe_in(pe),
		.pad_out(pdo), .pad_oe_out(poe));
	pioc_pad_model pm (.drv_in(pdo), .oe_in(poe), .ext_low_in(ext), .level_out(pad));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		sel <= 1'h1;
		wr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		en <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1 && ++n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		r = rd;
		sel <= 1'h0;
		en <= 1'h0;
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) mcnt <= mcnt + 2'h1;
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		#200000;
		err_total++;
		summarize;
	end
	initial begin
		{rst_b, sel, en, wr, mcnt, addr, wd, ext, po} = '0;
		pe = '1;
		cke = 1'h1;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk("read", rows[i].d, r);
		end
		repeat (8) @(posedge clk);
		chk("od drive", 32'h30, poe & 32'hF0);
		chk("od pad", 32'h0000F030, pdo & 32'hFFFF);
		apb(1'h0, 12'h024, 32'h0);
		chk("pin", 32'h0000F0F0, r);
		apb(1'h1, 12'h040, 32'h00000080);
		repeat (3) @(posedge clk);
		chk("periph low", 32'h80, poe & 32'h80);
		po <= '1;
		repeat (3) @(posedge clk);
		chk("periph high", 32'h0, poe & 32'h80);
		ext <= 32'h10;
		repeat (12) @(posedge clk);
		apb(1'h0, 12'h024, 32'h0);
		chk("filtered", 32'h0000F0E0, r);
		cke <= 1'h0;
		ext <= 32'h0;
		repeat (12) @(posedge clk);
		apb(1'h0, 12'h024, 32'h0);
		chk("frozen", 32'h0000F0E0, r);
		cke <= 1'h1;
		repeat (12) @(posedge clk);
		apb(1'h0, 12'h024, 32'h0);
		chk("live", 32'h0000F0F0, r);
		ext <= 32'h10;
		@(posedge clk);
		ext <= 32'h0;
		repeat (12) @(posedge clk);
		apb(1'h0, 12'h024, 32'h0);
		chk("glitch", 32'h0000F0F0, r);
		lowseen = 1'h0;
		ext <= 32'h10;
		repeat (4) @(posedge clk);
		ext <= 32'h0;
		repeat (8) begin
			apb(1'h0, 12'h024, 32'h0);
			lowseen = lowseen | ~r[4];
		end
		chk("pulse", 32'h1, {31'h0, lowseen});
		rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		chk("oe after reset", 32'h0, poe);
		chk("pad after reset", 32'h0, pdo);
		apb(1'h0, 12'h014, 32'h0);
		chk("mask reset", 32'h0, r);
		apb(1'h0, 12'h020, 32'h0);
		chk("od reset", 32'h0, r);
		summarize;
	end
endmodule
